// File: design/gdio_top.sv
// General digital I/O port: APB registers, pad control and input path
//
// Chosen here: the register offsets and register access over APB.
module gdio_top #(
    parameter int WIDTH = gdio_pkg::GDIO_WIDTH
) (
    input wire logic REF_CLK_IN,
    input wire logic ARST_N_IN,
    input wire logic CLK_EN_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [gdio_pkg::GDIO_AW-1:0] PADDR_IN,
    input wire logic [gdio_pkg::GDIO_DW-1:0] PWDATA_IN,
    input wire logic [3:0] PSTRB_IN,
    output logic [gdio_pkg::GDIO_DW-1:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    input wire logic [WIDTH-1:0] PAD_IN,
    output logic [WIDTH-1:0] PAD_OUT_OUT,
    output logic [WIDTH-1:0] PAD_OE_OUT,
    output logic [WIDTH-1:0] PAD_PULLUP_OUT,
    input wire logic SLEEP_IN,
    input wire logic [WIDTH-1:0] CLAMP_BYPASS_IN,
    output logic [WIDTH-1:0] DIGITAL_IN_OUT
);
    import gdio_pkg::*;

    logic [WIDTH-1:0] output_latch_ff;
    logic [WIDTH-1:0] nxt_output_latch;
    logic [WIDTH-1:0] direction_ff;
    logic [WIDTH-1:0] nxt_direction;
    logic global_pullup_disable_ff;
    logic nxt_global_pullup_disable;
    logic [WIDTH-1:0] pullup_ff;
    logic [WIDTH-1:0] nxt_pullup;
    logic [GDIO_DW-1:0] prdata_ff;
    logic [GDIO_DW-1:0] nxt_prdata;
    logic setup_cyc;
    logic wr_take;
    logic hit;
    logic [WIDTH-1:0] wdata;

    gdio_pin_if #(.WIDTH(WIDTH)) pins ();

    // Apply one of the bit-vector write operations
    function automatic logic [WIDTH-1:0] gdio_apply(
        input logic [WIDTH-1:0] cur,
        input logic [WIDTH-1:0] data,
        input gdio_op_t op
    );
        logic [WIDTH-1:0] res;
        res = cur;
        unique case (op)
            GDIO_OP_LOAD: res = data;
            GDIO_OP_SET: res = cur | data;
            GDIO_OP_CLR: res = cur & ~data;
            GDIO_OP_TOG: res = cur ^ data;
        endcase
        return res;
    endfunction

    function automatic logic gdio_mapped(input logic [GDIO_AW-1:0] a);
        return a == GDIO_OFF_LATCH || a == GDIO_OFF_DIR
            || a == GDIO_OFF_SAMPLE || a == GDIO_OFF_CTRL
            || a == GDIO_OFF_LATCH_SET || a == GDIO_OFF_LATCH_CLR
            || a == GDIO_OFF_DIR_SET || a == GDIO_OFF_DIR_CLR;
    endfunction

    // ==========================================================
    // APB handshake: zero wait states, unmapped access errors
    assign hit = gdio_mapped(PADDR_IN);
    assign setup_cyc = PSEL_IN && !PENABLE_IN;
    // Lane 0 carries the whole port; other lanes are ignored
    assign wr_take = CLK_EN_IN && PSEL_IN && PENABLE_IN && PWRITE_IN
        && hit && PSTRB_IN[0];
    assign wdata = PWDATA_IN[WIDTH-1:0];
    assign PREADY_OUT = 1'b1;
    assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !hit;

    // ==========================================================
    // Port registers
    always_comb
    begin
        nxt_output_latch = output_latch_ff;
        nxt_direction = direction_ff;
        nxt_global_pullup_disable = global_pullup_disable_ff;
        if (wr_take)
        begin
            unique case (PADDR_IN)
                GDIO_OFF_LATCH:
                    nxt_output_latch = gdio_apply(output_latch_ff, wdata,
                        GDIO_OP_LOAD);
                GDIO_OFF_DIR:
                    nxt_direction = gdio_apply(direction_ff, wdata,
                        GDIO_OP_LOAD);
                GDIO_OFF_SAMPLE:
                    nxt_output_latch = gdio_apply(output_latch_ff, wdata,
                        GDIO_OP_TOG);
                GDIO_OFF_CTRL:
                    nxt_global_pullup_disable =
                        PWDATA_IN[GDIO_CTRL_PULLUP_DIS_POS];
                GDIO_OFF_LATCH_SET:
                    nxt_output_latch = gdio_apply(output_latch_ff, wdata,
                        GDIO_OP_SET);
                GDIO_OFF_LATCH_CLR:
                    nxt_output_latch = gdio_apply(output_latch_ff, wdata,
                        GDIO_OP_CLR);
                GDIO_OFF_DIR_SET:
                    nxt_direction = gdio_apply(direction_ff, wdata,
                        GDIO_OP_SET);
                GDIO_OFF_DIR_CLR:
                    nxt_direction = gdio_apply(direction_ff, wdata,
                        GDIO_OP_CLR);
                default:
                    nxt_direction = direction_ff;
            endcase
        end
        // Per-pin term and the global disable only: every pin is independent of its neighbours
        nxt_pullup = ~nxt_direction & nxt_output_latch
            & {WIDTH{~nxt_global_pullup_disable}};
    end

    // Async reset clears every control flop, so pins float with no clock
    always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
        begin
            output_latch_ff <= GDIO_LATCH_RST;
            direction_ff <= GDIO_DIR_RST;
            global_pullup_disable_ff <= GDIO_PULLUP_DIS_RST;
            pullup_ff <= '0;
        end
        else if (CLK_EN_IN)
        begin
            output_latch_ff <= nxt_output_latch;
            direction_ff <= nxt_direction;
            global_pullup_disable_ff <= nxt_global_pullup_disable;
            pullup_ff <= nxt_pullup;
        end
    end

    // ==========================================================
    // Read data, captured in the setup cycle
    always_comb
    begin
        nxt_prdata = prdata_ff;
        if (CLK_EN_IN && setup_cyc && !PWRITE_IN)
        begin
            nxt_prdata = '0;
            unique case (PADDR_IN)
                GDIO_OFF_LATCH:
                    nxt_prdata[WIDTH-1:0] = output_latch_ff;
                GDIO_OFF_DIR:
                    nxt_prdata[WIDTH-1:0] = direction_ff;
                GDIO_OFF_SAMPLE:
                    nxt_prdata[WIDTH-1:0] = pins.sample;
                GDIO_OFF_CTRL:
                    nxt_prdata[GDIO_CTRL_PULLUP_DIS_POS] =
                        global_pullup_disable_ff;
                default:
                    nxt_prdata = '0;
            endcase
        end
    end

    always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
        begin
            prdata_ff <= '0;
        end
        else
        begin
            prdata_ff <= nxt_prdata;
        end
    end

    assign PRDATA_OUT = prdata_ff;

    // ==========================================================
    // Pad drive and input path
    assign PAD_OE_OUT = direction_ff;
    assign PAD_OUT_OUT = output_latch_ff;
    assign PAD_PULLUP_OUT = pullup_ff;
    // Clamped level goes out raw, so an interrupt detector sees the
    // drop to zero in sleep and the rise on wake as a real change
    assign DIGITAL_IN_OUT = pins.din;
    assign pins.pad = PAD_IN;
    assign pins.bypass = CLAMP_BYPASS_IN;
    assign pins.sleep = SLEEP_IN;

    gdio_sync #(.WIDTH(WIDTH)) u_sync (
        .clk_in(REF_CLK_IN),
        .rst_n_in(ARST_N_IN),
        .ce_in(CLK_EN_IN),
        .pins(pins.sync_mp)
    );

    // ==========================================================
    // Assertions
    default clocking cb @(posedge REF_CLK_IN);
    endclocking
    default disable iff (!ARST_N_IN);

    a_reset_tri_state: assert property (
        disable iff (1'b0)
        !ARST_N_IN |-> (PAD_OE_OUT == '0 && PAD_PULLUP_OUT == '0))
        else $error("pins not tri-stated in reset");

    a_pullup_only_input: assert property (
        PAD_PULLUP_OUT == (~direction_ff & output_latch_ff
            & {WIDTH{~global_pullup_disable_ff}}))
        else $error("pull-up does not match direction and latch");

    a_pullup_dis_all: assert property (
        $rose(global_pullup_disable_ff) |-> PAD_PULLUP_OUT == '0)
        else $error("pull-up left on with global disable");

    a_drive_follows_latch: assert property (
        wr_take && PADDR_IN == GDIO_OFF_LATCH |=>
            (PAD_OUT_OUT & PAD_OE_OUT) == ($past(wdata) & direction_ff))
        else $error("driven value differs from written latch");

    a_toggle_on_sample: assert property (
        wr_take && PADDR_IN == GDIO_OFF_SAMPLE |=>
            output_latch_ff == ($past(output_latch_ff) ^ $past(wdata))
            && direction_ff == $past(direction_ff))
        else $error("sample write did not toggle latch");

    a_set_keeps_others: assert property (
        wr_take && PADDR_IN == GDIO_OFF_DIR_SET |=>
            direction_ff == ($past(direction_ff) | $past(wdata)))
        else $error("direction set disturbed other bits");

    a_clear_keeps_others: assert property (
        wr_take && PADDR_IN == GDIO_OFF_LATCH_CLR |=>
            output_latch_ff == ($past(output_latch_ff) & ~$past(wdata)))
        else $error("latch clear disturbed other bits");

    a_sleep_clamp: assert property (
        (pins.din & {WIDTH{SLEEP_IN}} & ~CLAMP_BYPASS_IN) == '0
        && (pins.din & CLAMP_BYPASS_IN) == (PAD_IN & CLAMP_BYPASS_IN))
        else $error("sleep clamp wrong");

    a_sync_one_period: assert property (
        CLK_EN_IN && $past(CLK_EN_IN) && $past(ARST_N_IN)
        |-> pins.sample == $past(pins.din))
        else $error("sample not one period behind pad");

    a_unmapped_error: assert property (
        PSEL_IN && PENABLE_IN && !hit |-> PSLVERR_OUT
        ##1 $stable(output_latch_ff) && $stable(direction_ff))
        else $error("unmapped access not refused");

    c_toggle_write: cover property (
        wr_take && PADDR_IN == GDIO_OFF_SAMPLE);
    c_pullup_on: cover property ($rose(PAD_PULLUP_OUT[0]));
    c_wake_edge: cover property (
        SLEEP_IN && PAD_IN[0] ##1 !SLEEP_IN ##[1:4] pins.sample[0]);
    c_set_then_read: cover property (
        wr_take && PADDR_IN == GDIO_OFF_LATCH_SET
        ##[1:4] setup_cyc && PADDR_IN == GDIO_OFF_SAMPLE);
endmodule

// File: design/gdio_pkg.sv
// Constants, register map and field layout of the general digital I/O port
//
// Summary of operation
// - Three locations: latch, direction, read-only sample; code maps eight, adding ctrl and four set/clear offsets
// - Single-bit set/clear never disturbs other pins
// - Writing one to sample toggles latch bit
// - Global pull-up disable turns off all pull-ups
// - Direction one means output, zero input
// - Pull-up only when input, latch one, enabled
// - Output drives latch value, ignores pull-up disable
// - Reset tri-states pins without a running clock
// - Pad readable in any direction through synchroniser
// - Latch stage transparent high, sample on rise
// - Written value reaches sample after one period
// - Deep sleep clamps digital input to ground
// - Interrupt or alternate function bypasses clamp
// - Clamp release gives apparent edge to interrupts
// - Alternate use of one pin leaves others free
// - Software pull-up switched off during reset
package gdio_pkg;
    localparam int GDIO_WIDTH = 8;
    localparam int GDIO_AW = 8;
    localparam int GDIO_DW = 32;
    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] GDIO_OFF_LATCH = 8'h00;
    localparam logic [7:0] GDIO_OFF_DIR = 8'h04;
    localparam logic [7:0] GDIO_OFF_SAMPLE = 8'h08;
    localparam logic [7:0] GDIO_OFF_CTRL = 8'h0c;
    localparam logic [7:0] GDIO_OFF_LATCH_SET = 8'h10;
    localparam logic [7:0] GDIO_OFF_LATCH_CLR = 8'h14;
    localparam logic [7:0] GDIO_OFF_DIR_SET = 8'h18;
    localparam logic [7:0] GDIO_OFF_DIR_CLR = 8'h1c;
    // ==========================================================
    // Fields and reset values
    localparam int GDIO_CTRL_PULLUP_DIS_POS = 0;
    localparam logic [7:0] GDIO_LATCH_RST = 8'h00;
    localparam logic [7:0] GDIO_DIR_RST = 8'h00;
    localparam logic [7:0] GDIO_SAMPLE_RST = 8'h00;
    localparam logic GDIO_PULLUP_DIS_RST = 1'b0;
    // ==========================================================
    // Timing: write to sample readback, in clock periods
    localparam int GDIO_READBACK_CYC = 1;
    // Write operations on a bit vector
    typedef enum logic [1:0] {
        GDIO_OP_LOAD = 2'h0,
        GDIO_OP_SET = 2'h1,
        GDIO_OP_CLR = 2'h3,
        GDIO_OP_TOG = 2'h2
    } gdio_op_t;
endpackage

// File: design/gdio_pin_if.sv
// Interface between the port register logic and the pad synchroniser
interface gdio_pin_if #(parameter int WIDTH = 8);
    logic [WIDTH-1:0] pad;
    logic [WIDTH-1:0] bypass;
    logic sleep;
    logic [WIDTH-1:0] din;
    logic [WIDTH-1:0] sample;
    modport top_mp (output pad, output bypass, output sleep,
                    input din, input sample);
    modport sync_mp (input pad, input bypass, input sleep,
                     output din, output sample);
endinterface

// File: design/gdio_sync.sv
// Input clamp and two-stage pad synchroniser for one port
module gdio_sync #(
    parameter int WIDTH = gdio_pkg::GDIO_WIDTH
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    gdio_pin_if.sync_mp pins
);
    import gdio_pkg::*;

    logic [WIDTH-1:0] latch_q;
    logic [WIDTH-1:0] sample_ff;
    logic [WIDTH-1:0] nxt_sample;

    // ==========================================================
    // Sleep clamp, ahead of the synchroniser
    always_comb
    begin
        pins.din = pins.pad & ~({WIDTH{pins.sleep}} & ~pins.bypass);
    end

    // ==========================================================
    // First stage: open while the clock is high, holds when it falls
    always_latch
    begin
        if (clk_in && ce_in)
        begin
            latch_q <= pins.din;
        end
    end

    always_comb
    begin
        nxt_sample = ce_in ? latch_q : sample_ff;
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            sample_ff <= GDIO_SAMPLE_RST;
        end
        else
        begin
            sample_ff <= nxt_sample;
        end
    end

    assign pins.sample = sample_ff;
endmodule

// File: verification/gdio_pad_model.sv
// Pad and board model that resolves the level seen at each port pin
module gdio_pad_model #(
    parameter int WIDTH = 8
) (
    input wire logic clk_in,
    input wire logic [WIDTH-1:0] oe_in,
    input wire logic [WIDTH-1:0] out_in,
    input wire logic [WIDTH-1:0] pullup_in,
    input wire logic [WIDTH-1:0] ext_en_in,
    input wire logic [WIDTH-1:0] ext_val_in,
    output logic [WIDTH-1:0] pad_out
);
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================================
    // Floating pads
    // Undriven pads wander each cycle so a stale level never passes
    logic [WIDTH-1:0] float_ff = '0;
    always_ff @(posedge clk_in)
        float_ff <= ~float_ff;
    // ==========================================================
    // Wire resolution
    always_comb
    begin
        for (int i = 0; i < WIDTH; i++)
        begin
            if (oe_in[i])
                pad_out[i] = out_in[i];
            else if (ext_en_in[i])
                pad_out[i] = ext_val_in[i];
            else if (pullup_in[i])
                pad_out[i] = 1'b1;
            else
                pad_out[i] = float_ff[i];
        end
    end
endmodule

// File: verification/tb_top.sv
// Self-checking testbench of the general digital I/O port
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import gdio_pkg::*;
    logic clk = 1'b0;
    logic rst_n;
    logic clk_en = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic sleep = 1'b0;
    logic [7:0] bypass = 8'h00;
    logic [7:0] ext_en = 8'h00;
    logic [7:0] ext_val = 8'h00;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] pad;
    logic [7:0] pad_out;
    logic [7:0] pad_oe;
    logic [7:0] pad_pu;
    logic [7:0] din;
    logic [31:0] rd;
    logic er;
    int num_errors = 0;
    int compares = 0;
    always #2.5 clk = ~clk;
    gdio_top DUT (.REF_CLK_IN(clk), .ARST_N_IN(rst_n), .CLK_EN_IN(clk_en),
        .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite),
        .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PSTRB_IN(pstrb),
        .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
        .PAD_IN(pad), .PAD_OUT_OUT(pad_out), .PAD_OE_OUT(pad_oe),
        .PAD_PULLUP_OUT(pad_pu), .SLEEP_IN(sleep),
        .CLAMP_BYPASS_IN(bypass), .DIGITAL_IN_OUT(din));
    gdio_pad_model pads (.clk_in(clk), .oe_in(pad_oe), .out_in(pad_out),
        .pullup_in(pad_pu), .ext_en_in(ext_en), .ext_val_in(ext_val),
        .pad_out(pad));
    // ==========================================================
    // Shared tasks
    task test_done;
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            num_errors++;
        end
    endtask
    task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++)
        begin
            @(posedge clk);
            if (pready === 1'b1)
                break;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 20)
        begin
            chk("pready", 32'h1, 32'h0);
            test_done();
        end
    endtask
    task rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        xfer(a, 1'b0, 32'h0);
        chk(nm, e, rd);
    endtask
    task pins(input logic [7:0] oe, input logic [7:0] o, input logic [7:0] p);
        @(negedge clk);
        chk("pad_oe", {24'h0, oe}, {24'h0, pad_oe});
        chk("pad_out", {24'h0, o}, {24'h0, pad_out});
        chk("pad_pullup", {24'h0, p}, {24'h0, pad_pu});
    endtask
    // ==========================================================
    // Scenarios
    task t_setclr;
        rchk("latch", GDIO_OFF_LATCH, 32'h0);
        rchk("dir", GDIO_OFF_DIR, 32'h0);
        pins(8'h00, 8'h00, 8'h00);
        // Latch before direction, so 00 to 11 passes pull-up input
        xfer(GDIO_OFF_LATCH, 1'b1, 32'h5a);
        xfer(GDIO_OFF_DIR_SET, 1'b1, 32'h0f);
        xfer(GDIO_OFF_DIR_CLR, 1'b1, 32'h01);
        rchk("dir", GDIO_OFF_DIR, 32'h0e);
        pins(8'h0e, 8'h5a, 8'h50);
        xfer(GDIO_OFF_LATCH_CLR, 1'b1, 32'h50);
        rchk("latch", GDIO_OFF_LATCH, 32'h0a);
        rchk("latch_set", GDIO_OFF_LATCH_SET, 32'h0);
        $display("test set_clear done");
    endtask
    task t_toggle;
        xfer(GDIO_OFF_SAMPLE, 1'b1, 32'h83);
        rchk("latch", GDIO_OFF_LATCH, 32'h89);
        xfer(GDIO_OFF_SAMPLE, 1'b1, 32'h00);
        rchk("latch", GDIO_OFF_LATCH, 32'h89);
        pins(8'h0e, 8'h89, 8'h81);
        xfer(GDIO_OFF_CTRL, 1'b1, 32'h1);
        pins(8'h0e, 8'h89, 8'h00);
        xfer(GDIO_OFF_CTRL, 1'b0, 32'h0);
        chk("ctrl", 32'h1, rd);
        xfer(GDIO_OFF_CTRL, 1'b1, 32'h0);
        $display("test toggle_pullup done");
    endtask
    task t_readback;
        ext_en <= 8'hf1;
        ext_val <= 8'h30;
        xfer(GDIO_OFF_LATCH, 1'b1, 32'h8f);
        @(posedge clk);
        rchk("sample", GDIO_OFF_SAMPLE, 32'h3e);
        @(posedge clk);
        ext_val <= 8'hc0;
        rchk("sample", GDIO_OFF_SAMPLE, 32'hce);
        @(posedge clk);
        sleep <= 1'b1;
        bypass <= 8'h44;
        @(negedge clk);
        chk("digital_in", 32'h44, {24'h0, din});
        rchk("sample", GDIO_OFF_SAMPLE, 32'h44);
        @(posedge clk);
        sleep <= 1'b0;
        @(negedge clk);
        chk("digital_in", 32'hce, {24'h0, din});
        $display("test readback_sleep done");
    endtask
    task t_reset;
        @(posedge clk);
        rst_n <= 1'b0;
        @(negedge clk);
        chk("pad_oe", 32'h0, {24'h0, pad_oe});
        chk("pad_pullup", 32'h0, {24'h0, pad_pu});
        @(posedge clk);
        rst_n <= 1'b1;
        rchk("latch", GDIO_OFF_LATCH, 32'h0);
        $display("test reset done");
    endtask
    task t_refused;
        xfer(8'h40, 1'b0, 32'h0);
        chk("pslverr", 32'h1, {31'h0, er});
        chk("prdata", 32'h0, rd);
        @(posedge clk);
        clk_en <= 1'b0;
        xfer(GDIO_OFF_LATCH, 1'b1, 32'hff);
        @(posedge clk);
        clk_en <= 1'b1;
        pstrb <= 4'he;
        xfer(GDIO_OFF_LATCH, 1'b1, 32'hff);
        pstrb <= 4'hf;
        rchk("latch", GDIO_OFF_LATCH, 32'h0);
        $display("test refused done");
    endtask
    initial
    begin
        // Driven from unknown so the reset edge reaches every async-reset flop in the DUT
        rst_n <= 1'b0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        t_setclr();
        t_toggle();
        t_readback();
        t_reset();
        t_refused();
        test_done();
    end
endmodule
